// file: inc/dpr_regs.svh
// Purpose: register offsets, reset values and field layout of the disparity point reconstruction block
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH

`define DPR_OFS_CTRL 8'h00
`define DPR_OFS_PICK 8'h04
`define DPR_OFS_FOCAL 8'h08
`define DPR_OFS_BASE 8'h0c
`define DPR_OFS_PRIN 8'h10
`define DPR_OFS_MERGE 8'h14
`define DPR_OFS_WIDTH 8'h18
`define DPR_OFS_STAT 8'h1c
`define DPR_OFS_COUNT 8'h20

`define DPR_RST_FOCAL 16'h0100
`define DPR_RST_BASE 32'h0001_0000
`define DPR_RST_PRIN 16'h0000
`define DPR_RST_MERGE 16'h1111
`define DPR_RST_WIDTH 16'h0280

// depth_length_unit code: disparity is always counted in pixels
`define DPR_UNIT_PIXEL 4'h1
`define DPR_BANK_DISP 1'b0
`define DPR_BANK_INT 1'b1
`define DPR_DIV_LAST 5'h1f
`define DPR_PH_RECIP 2'h0
`define DPR_PH_TCOL 2'h1
`define DPR_PH_TROW 2'h2
`define DPR_FIFO_DEPTH 16
`define DPR_REC_W 130

`endif

// file: inc/dpr_pkg.sv
// Purpose: types of the disparity point reconstruction block
// Assumes: constants live in dpr_regs.svh
// Notes: one packed struct holds all state of the core except the record buffer
package dpr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_PUSH = 3'b100
    } dpr_state_t;

    typedef struct packed {
        dpr_state_t st;
        logic en;
        logic bank;
        logic [1:0][15:0] focal;
        logic [1:0][15:0] pcol;
        logic [1:0][15:0] prow;
        logic [1:0][15:0] merge;
        logic [31:0] base;
        logic [15:0] width;
        logic [15:0] col;
        logic [15:0] row;
        logic [15:0] u;
        logic [15:0] v;
        logic inv;
        logic inf;
        logic [1:0] phase;
        logic ld;
        logic [4:0] bitc;
        logic [16:0] rem;
        logic [31:0] acc;
        logic [31:0] q;
        logic [15:0] tcol;
        logic [15:0] trow;
        logic [15:0] d;
        logic [31:0] pcount;
        logic rdy;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dpr_core_t;

endpackage

// file: core/dpr_fifo.sv
// Purpose: record buffer between the reconstruction datapath and the point consumer
// Assumes: single clock, valid/ready on both sides
// Notes: read data come out of a register; one extra word sits in that register
`timescale 1ns/100ps
module dpr_fifo #(
    parameter int W = 130,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] dout;
    } dpr_fifo_t;

    dpr_fifo_t r;
    dpr_fifo_t n;

    assign in_ready = (r.cnt != (AW+1)'(D));
    assign out_valid = r.ov;
    assign out_data = r.dout;

    always_comb begin
        n = r;
        if (r.ov && out_ready) begin
            n.ov = 1'b0;
        end
        // refill the output register from memory as soon as it empties
        if (!n.ov && (r.cnt != '0)) begin
            n.dout = r.mem[r.rd];
            n.ov = 1'b1;
            n.rd = r.rd + 1'b1;
            n.cnt = n.cnt - 1'b1;
        end
        if (in_valid && in_ready) begin
            n.mem[r.wr] = in_data;
            n.wr = r.wr + 1'b1;
            n.cnt = n.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// file: core/dpr_core.sv
// Purpose: turns a raster stream of disparity pixels into cartesian points plus texture coordinates
// Assumes: pclk 125 MHz, presetn asynchronous active low, stream inputs on pclk
// Notes: one shared serial divider, about 100 cycles per pixel, about 70 for invalid or zero disparity; apb answers with no wait state
//
// What this block does
// RQ1: distance unit of the disparity component reads back as pixel.
// RQ2: focal length counts output pixels, after pixel merging and subsampling.
// RQ3: stereo baseline is held in metres, unsigned Q16.16.
// RQ4: X and Y are principal-point offsets times baseline over disparity.
// RQ5: Z is focal length times baseline over disparity.
// RQ6: zero disparity is never divided; pixel is tagged at infinity.
// RQ7: invalid disparity gives no coordinates and is tagged invalid.
// RQ8: X, Y, Z keep the baseline unit, no conversion.
// RQ9: column, row and principal point are all region relative.
// RQ10: scale ratio is disparity merge times subsample over intensity's.
// RQ11: focal length and principal point are banked per image component.
// RQ12: one texture coordinate per disparity pixel, position times axis ratio.
// RQ13: one record per input pixel, raster order kept.
`timescale 1ns/100ps
`include "dpr_regs.svh"
module dpr_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // disparity stream in
    input wire logic disp_valid,
    output logic disp_ready,
    input wire logic [15:0] disp_data,
    input wire logic disp_invalid,
    input wire logic disp_sof,
    // point record out
    output logic out_valid,
    input wire logic out_ready,
    output logic [31:0] out_x,
    output logic [31:0] out_y,
    output logic [31:0] out_z,
    output logic [15:0] out_tex_col,
    output logic [15:0] out_tex_row,
    output logic out_invalid,
    output logic out_infinity
);
    dpr_pkg::dpr_core_t r;
    dpr_pkg::dpr_core_t n;

    logic fifo_in_ready;
    logic [`DPR_REC_W-1:0] rec;
    logic [`DPR_REC_W-1:0] fifo_out;
    logic [31:0] div_a;
    logic [15:0] div_b;
    logic [48:0] step;
    logic [16:0] dx;
    logic [16:0] dy;
    logic special;

    // one restoring divide step: {remainder, shifted dividend with quotient bit}
    function automatic logic [48:0] div_step(input logic [16:0] rem, input logic [31:0] a,
                                             input logic [15:0] b);
        logic [16:0] t;
        t = {rem[15:0], a[31]};
        if (t >= {1'b0, b}) begin
            div_step = {17'(t - {1'b0, b}), a[30:0], 1'b1};
        end else begin
            div_step = {t, a[30:0], 1'b0};
        end
    endfunction

    // merge times subsample for one axis; a zero field counts as one to keep the divisor nonzero
    function automatic logic [7:0] axis_scale(input logic [3:0] merge, input logic [3:0] sub);
        logic [3:0] m;
        logic [3:0] s;
        m = (merge == 4'h0) ? 4'h1 : merge;
        s = (sub == 4'h0) ? 4'h1 : sub;
        axis_scale = m * s;
    endfunction

    // signed pixel count times metres per pixel; result stays in the baseline's Q16.16 metres
    function automatic logic [31:0] coord(input logic [16:0] px, input logic [31:0] q);
        logic signed [49:0] p;
        p = $signed(px) * $signed({1'b0, q});
        coord = p[31:0]; // RQ8
    endfunction

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a[31:6] == '0) && (a[1:0] == 2'b00) && (a[5:2] <= 4'h8);
    endfunction

    // ratio applied as position times disparity scale, divided by intensity scale
    always_comb begin
        div_a = r.base;
        div_b = r.d;
        unique case (r.phase)
            `DPR_PH_TCOL: begin
                div_a = {8'h00, 24'(r.u * axis_scale(r.merge[`DPR_BANK_DISP][3:0],
                                                     r.merge[`DPR_BANK_DISP][11:8]))}; // RQ10
                div_b = {8'h00, axis_scale(r.merge[`DPR_BANK_INT][3:0], r.merge[`DPR_BANK_INT][11:8])};
            end
            `DPR_PH_TROW: begin
                div_a = {8'h00, 24'(r.v * axis_scale(r.merge[`DPR_BANK_DISP][7:4],
                                                     r.merge[`DPR_BANK_DISP][15:12]))}; // RQ10
                div_b = {8'h00, axis_scale(r.merge[`DPR_BANK_INT][7:4], r.merge[`DPR_BANK_INT][15:12])};
            end
            default: begin
                div_a = r.base; // RQ5
                div_b = r.d;
            end
        endcase
    end

    assign step = div_step(r.rem, r.acc, div_b);
    // principal point banked to the disparity component; no region origin correction needed
    assign dx = {1'b0, r.u} - {1'b0, r.pcol[`DPR_BANK_DISP]}; // RQ9 RQ11
    assign dy = {1'b0, r.v} - {1'b0, r.prow[`DPR_BANK_DISP]}; // RQ9 RQ11
    assign special = r.inv || r.inf;

    always_comb begin
        rec = '0;
        if (!special) begin
            rec[129:98] = coord(dx, r.q); // RQ4
            rec[97:66] = coord(dy, r.q); // RQ4
            rec[65:34] = coord({1'b0, r.focal[`DPR_BANK_DISP]}, r.q); // RQ5 RQ2
        end
        rec[33:18] = r.tcol; // RQ12
        rec[17:2] = r.trow; // RQ12
        rec[1] = r.inv; // RQ7
        rec[0] = r.inf; // RQ6
    end

    always_comb begin
        n = r;
        // apb: decode in setup, answer in access with no wait state
        n.pready = psel && !penable;
        n.pslverr = 1'b0;
        if (psel && !penable) begin
            n.pslverr = !addr_hit(paddr);
            n.prdata = '0;
            // refused reads return zero even where the low address bits alias a register
            if (!pwrite && addr_hit(paddr)) begin
                case (paddr[7:0])
                    `DPR_OFS_CTRL: n.prdata = {31'h0, r.en};
                    `DPR_OFS_PICK: n.prdata = {31'h0, r.bank};
                    `DPR_OFS_FOCAL: n.prdata = {16'h0, r.focal[r.bank]}; // RQ11
                    `DPR_OFS_BASE: n.prdata = r.base; // RQ3
                    `DPR_OFS_PRIN: n.prdata = {r.prow[r.bank], r.pcol[r.bank]}; // RQ11
                    `DPR_OFS_MERGE: n.prdata = {16'h0, r.merge[r.bank]};
                    `DPR_OFS_WIDTH: n.prdata = {16'h0, r.width};
                    `DPR_OFS_STAT: n.prdata = {27'h0, r.st != dpr_pkg::ST_IDLE, `DPR_UNIT_PIXEL}; // RQ1
                    `DPR_OFS_COUNT: n.prdata = r.pcount;
                    default: n.prdata = '0;
                endcase
            end
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            case (paddr[7:0])
                `DPR_OFS_CTRL: n.en = pwdata[0];
                `DPR_OFS_PICK: n.bank = pwdata[0];
                `DPR_OFS_FOCAL: n.focal[r.bank] = pwdata[15:0]; // RQ11
                `DPR_OFS_BASE: n.base = pwdata; // RQ3
                `DPR_OFS_PRIN: begin
                    n.pcol[r.bank] = pwdata[15:0]; // RQ11
                    n.prow[r.bank] = pwdata[31:16];
                end
                `DPR_OFS_MERGE: n.merge[r.bank] = pwdata[15:0];
                `DPR_OFS_WIDTH: n.width = pwdata[15:0];
                default: begin
                end
            endcase
        end

        unique case (r.st)
            dpr_pkg::ST_IDLE: begin
                n.rdy = r.en;
                if (disp_valid && r.rdy) begin
                    n.rdy = 1'b0;
                    // raster position counted from the region's own origin
                    n.u = disp_sof ? 16'h0 : r.col; // RQ9 RQ13
                    n.v = disp_sof ? 16'h0 : r.row;
                    n.col = n.u + 1'b1;
                    n.row = n.v;
                    if (n.u + 1'b1 >= r.width) begin
                        n.col = 16'h0;
                        n.row = n.v + 1'b1;
                    end
                    n.d = disp_data;
                    n.inv = disp_invalid; // RQ7
                    n.inf = !disp_invalid && (disp_data == 16'h0); // RQ6
                    n.q = '0;
                    // skip the reciprocal so zero is never a divisor
                    n.phase = (disp_invalid || disp_data == 16'h0) ? `DPR_PH_TCOL : `DPR_PH_RECIP; // RQ6 RQ7
                    n.ld = 1'b1;
                    n.st = dpr_pkg::ST_DIV;
                end
            end
            dpr_pkg::ST_DIV: begin
                if (r.ld) begin
                    n.ld = 1'b0;
                    n.acc = div_a;
                    n.rem = '0;
                    n.bitc = '0;
                end else begin
                    n.rem = step[48:32];
                    n.acc = step[31:0];
                    n.bitc = r.bitc + 1'b1;
                    if (r.bitc == `DPR_DIV_LAST) begin
                        n.ld = 1'b1;
                        n.phase = r.phase + 1'b1;
                        unique case (r.phase)
                            `DPR_PH_RECIP: n.q = step[31:0]; // RQ4 RQ5
                            `DPR_PH_TCOL: n.tcol = step[15:0]; // RQ12
                            default: begin
                                n.trow = step[15:0]; // RQ12
                                n.ld = 1'b0;
                                n.st = dpr_pkg::ST_PUSH;
                            end
                        endcase
                    end
                end
            end
            dpr_pkg::ST_PUSH: begin
                // full buffer stalls here, which in turn holds disp_ready low
                if (fifo_in_ready) begin
                    n.pcount = r.pcount + 1'b1; // RQ13
                    n.phase = `DPR_PH_RECIP;
                    n.st = dpr_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= dpr_pkg::ST_IDLE;
            r.focal <= {`DPR_RST_FOCAL, `DPR_RST_FOCAL};
            r.pcol <= {`DPR_RST_PRIN, `DPR_RST_PRIN};
            r.prow <= {`DPR_RST_PRIN, `DPR_RST_PRIN};
            r.merge <= {`DPR_RST_MERGE, `DPR_RST_MERGE};
            r.base <= `DPR_RST_BASE;
            r.width <= `DPR_RST_WIDTH;
        end else begin
            r <= n;
        end
    end

    dpr_fifo #(
        .W(`DPR_REC_W),
        .D(`DPR_FIFO_DEPTH)
    ) dpr_fifo_i (
        .clk(pclk),
        .rstn(presetn),
        .in_valid(r.st == dpr_pkg::ST_PUSH), // RQ13
        .in_ready(fifo_in_ready),
        .in_data(rec),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(fifo_out)
    );

    assign out_x = fifo_out[129:98];
    assign out_y = fifo_out[97:66];
    assign out_z = fifo_out[65:34];
    assign out_tex_col = fifo_out[33:18];
    assign out_tex_row = fifo_out[17:2];
    assign out_invalid = fifo_out[1];
    assign out_infinity = fifo_out[0];
    assign disp_ready = r.rdy;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
endmodule

// file: tb/dpr_core_props.sv
// Purpose: port-level properties of the disparity point reconstruction core
// Assumes: single pclk domain, presetn async active low
// Notes: bound into dpr_core below
`timescale 1ns/100ps
`include "dpr_regs.svh"
module dpr_core_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // streams
    input wire logic disp_valid,
    input wire logic disp_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [31:0] out_x,
    input wire logic [31:0] out_y,
    input wire logic [31:0] out_z,
    input wire logic [15:0] out_tex_col,
    input wire logic out_invalid,
    input wire logic out_infinity
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unit_pixel: assert property (
        psel && penable && pready && !pwrite && paddr == 32'h1c |-> prdata[3:0] == `DPR_UNIT_PIXEL)
        else $error("distance unit not pixel");
    a_inf_no_coord: assert property (
        out_valid && out_infinity |-> {out_x, out_y, out_z} == 96'h0) else $error("infinity point has coordinates");
    a_inv_no_coord: assert property (
        out_valid && out_invalid |-> {out_x, out_y, out_z} == 96'h0) else $error("invalid point has coordinates");
    a_tags_exclusive: assert property (
        out_valid |-> !(out_invalid && out_infinity)) else $error("both tags set");
    a_rec_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable({out_x, out_y, out_z, out_tex_col}))
        else $error("record changed before taken");
    a_take_once: assert property (
        disp_valid && disp_ready |=> !disp_ready [*8]) else $error("second pixel taken too early");
    a_apb_answer: assert property (
        psel && !penable |=> pready) else $error("no answer after setup");
    a_unmapped_err: assert property (
        psel && !penable && paddr[31:6] != 26'h0 |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    cover property (out_valid && out_ready && out_infinity);
    cover property (out_valid && out_ready && out_invalid);
    cover property (pslverr);
endmodule
bind dpr_core dpr_core_props dpr_core_props_i (.*);

// file: tb/dpr_stream_peer.sv
// Purpose: disparity source and point consumer around the core
// Assumes: records arrive as {x, y, z, tex_col, tex_row, invalid, infinity}
// Notes: mode 0 always ready, 1 every other cycle, 2 stalled
`timescale 1ns/100ps
module dpr_stream_peer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // disparity source
    output logic disp_valid,
    input wire logic disp_ready,
    output logic [15:0] disp_data,
    output logic disp_invalid,
    output logic disp_sof,
    // point consumer
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [129:0] out_rec,
    input wire logic [1:0] mode
);
    logic [129:0] recs[$];
    logic tick = 1'b0;
    initial begin
        disp_valid = 1'b0;
        disp_data = 16'h0;
        disp_invalid = 1'b0;
        disp_sof = 1'b0;
        out_ready = 1'b0;
    end
    always @(posedge pclk) begin
        tick <= !tick;
        if (out_valid && out_ready) begin
            recs.push_back(out_rec);
        end
        out_ready <= presetn && (mode == 2'h0 || (mode == 2'h1 && tick));
    end
    // pixels go one at a time in raster order; released lines show no stale value
    task send(input logic [15:0] d, input logic inv, input logic sof, output logic ok);
        int n;
        n = 0;
        @(posedge pclk);
        disp_valid <= 1'b1;
        disp_data <= d;
        disp_invalid <= inv;
        disp_sof <= sof;
        do begin
            @(posedge pclk);
            n++;
        end while (disp_ready !== 1'b1 && n < 400);
        ok = (n < 400);
        disp_valid <= 1'b0;
        disp_data <= ~d;
        disp_invalid <= ~inv;
        disp_sof <= 1'b0;
    endtask
endmodule

// file: tb/disparity_point_reconstruction_tb.sv
// Purpose: self-checking bench of the disparity point reconstruction core
// Assumes: apb answers without wait states, 8 ns clock
// Notes: expected points worked out by hand for base 2 m
`timescale 1ns/100ps
`include "dpr_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module disparity_point_reconstruction_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, out_x, out_y, out_z, rd;
    logic pready, pslverr, disp_valid, disp_ready, disp_invalid, disp_sof, out_valid, out_ready;
    logic out_invalid, out_infinity, e, ok;
    logic [15:0] disp_data, out_tex_col, out_tex_row;
    logic [1:0] mode = 2'h1;
    int err_total = 0;
    int n_checks = 0;
    int nt;
    logic [17:0] pix[5] = '{{16'h4, 2'b01}, {16'h0, 2'b00}, {16'h5, 2'b10}, {16'h1, 2'b00}, {16'h2, 2'b00}};
    logic [129:0] exp_r[5] = '{
        {32'hffff0000, 32'hffff8000, 32'h00800000, 16'h0, 16'h0, 2'b00},
        {96'h0, 16'h1, 16'h0, 2'b01},
        {96'h0, 16'h3, 16'h0, 2'b10},
        {32'h00020000, 32'hfffe0000, 32'h02000000, 16'h4, 16'h0, 2'b00},
        {32'hfffe0000, 32'h0, 32'h01000000, 16'h0, 16'h2, 2'b00}};

    dpr_core dpr_core_i (.*);
    dpr_stream_peer dpr_stream_peer_i (.*,
        .out_rec({out_x, out_y, out_z, out_tex_col, out_tex_row, out_invalid, out_infinity}));

    initial begin
        forever #4 pclk = ~pclk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            `CHK(n, 0)
            end_of_test;
        end
    endtask

    task rchk(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask

    task wait_recs(input int k);
        int n;
        n = 0;
        while (dpr_stream_peer_i.recs.size() < k && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        `CHK(dpr_stream_peer_i.recs.size(), k)
        if (n >= 3000) end_of_test;
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`DPR_OFS_FOCAL, `DPR_RST_FOCAL);
        rchk(`DPR_OFS_BASE, `DPR_RST_BASE);
        rchk(`DPR_OFS_PRIN, `DPR_RST_PRIN);
        rchk(`DPR_OFS_MERGE, `DPR_RST_MERGE);
        rchk(`DPR_OFS_WIDTH, `DPR_RST_WIDTH);
        rchk(`DPR_OFS_CTRL, 32'h0);
        apb(1'b1, `DPR_OFS_STAT, 32'hffff_ffff);
        rchk(`DPR_OFS_STAT, 32'h1);
        apb(1'b0, 32'h24, 32'h0);
        `CHK({e, rd}, {1'b1, 32'h0})
        $display("test registers done");
        // intensity bank must not disturb the disparity bank
        apb(1'b1, `DPR_OFS_PICK, 32'h1);
        apb(1'b1, `DPR_OFS_FOCAL, 32'h0200);
        rchk(`DPR_OFS_FOCAL, 32'h0200);
        // intensity scale 2 across, 1 down
        apb(1'b1, `DPR_OFS_MERGE, 32'h1112);
        apb(1'b1, `DPR_OFS_PICK, 32'h0);
        rchk(`DPR_OFS_FOCAL, 32'h0100);
        rchk(`DPR_OFS_MERGE, `DPR_RST_MERGE);
        $display("test banks done");
        // disparity scale 3 across, 2 down; zero subsample field counts as one
        apb(1'b1, `DPR_OFS_MERGE, 32'h2013);
        apb(1'b1, `DPR_OFS_BASE, 32'h0002_0000);
        apb(1'b1, `DPR_OFS_PRIN, 32'h0001_0002);
        apb(1'b1, `DPR_OFS_WIDTH, 32'h4);
        apb(1'b1, `DPR_OFS_CTRL, 32'h1);
        // aliases above the register window are refused; a dropped write keeps width 4
        apb(1'b1, 32'h118, 32'h1);
        `CHK(e, 1'b1)
        apb(1'b0, 32'h100, 32'h0);
        `CHK({e, rd}, {1'b1, 32'h0})
        for (int i = 0; i < 5; i++) begin
            dpr_stream_peer_i.send(pix[i][17:2], pix[i][1], pix[i][0], ok);
            `CHK(ok, 1'b1)
            if (!ok) end_of_test;
        end
        wait_recs(5);
        for (int i = 0; i < 5; i++) begin
            `CHK(dpr_stream_peer_i.recs[i], exp_r[i])
        end
        rchk(`DPR_OFS_COUNT, 32'h5);
        $display("test points done");
        // consumer stalled: the buffer fills until pixels are refused
        mode <= 2'h2;
        for (nt = 0; nt < 18; nt++) begin
            dpr_stream_peer_i.send(16'h0, 1'b0, nt == 0, ok);
            `CHK(ok, 1'b1)
            if (!ok) end_of_test;
        end
        // 16 in memory, one in the output register, one parked in the core
        repeat (200) @(posedge pclk);
        `CHK(disp_ready, 1'b0)
        rchk(`DPR_OFS_STAT, 32'h11);
        mode <= 2'h0;
        wait_recs(5 + nt);
        `CHK(dpr_stream_peer_i.recs[5 + nt - 1][1:0], 2'b01)
        rchk(`DPR_OFS_COUNT, 5 + nt);
        $display("test fill done");
        end_of_test;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        end_of_test;
    end
endmodule
